// >>> src/fan_start_temperature_ceiling_consts.vh
// Constants for the fan-start interval and duty-ceiling register bank.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef FAN_START_TEMPERATURE_CEILING_CONSTS_VH
`define FAN_START_TEMPERATURE_CEILING_CONSTS_VH

// ==========================================================
// Register indices, matched against address bits [9:2] (printed offsets are indices)
`define IDX_INTERVAL      8'h37
`define IDX_FAN1_CEIL     8'h38
`define IDX_FAN2_CEIL     8'h39
`define IDX_FAN3_CEIL     8'h3A
`define IDX_DYN_CTRL1     8'h36
`define IDX_CONFIG1       8'h40
`define IDX_CONFIG4       8'h7D
`define IDX_FAN_DEMAND    8'h30
`define IDX_ADJ_STATUS    8'h50

// ==========================================================
// Field positions
`define FLD_REMOTE1_LO    0
`define FLD_LOCAL_LO      3
`define FLD_REMOTE2_LO    6
`define FLD_DYN1_R2_MSB   0
`define FLD_CFG1_LOCK     1
`define FLD_CFG1_FORCE    3
`define FLD_CFG4_CEIL_ALM 3

// ==========================================================
// Reset values
`define RST_INTERVAL      8'h00
`define RST_CEILING       8'hFF
`define RST_DYN_CTRL1     8'h00
`define RST_CONFIG1       8'h01
`define RST_CONFIG4       8'h00
`define RST_DEMAND        8'h00
`define DUTY_FULL         8'hFF

// ==========================================================
// Interval timing: decrease base count, increase is one more doubling
`define DEC_BASE_CYCLES   12'h008
`define INC_SHIFT_EXTRA   1

// AXI responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// >>> src/interval_timer.v
// One channel's adjustment interval timer.
// Assumes mon_tick marks one monitoring cycle; code is the 3-bit interval code.
`timescale 1ns/100ps
`include "fan_start_temperature_ceiling_consts.vh"

module interval_timer #(
	parameter CNT_W = 12
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire             mon_tick,
	input  wire [2:0]       code,
	input  wire             adjusted,
	output reg              dec_ready,
	output reg              inc_ready
);

	reg  [CNT_W-1:0] count_reg;
	wire [CNT_W-1:0] dec_limit;
	wire [CNT_W-1:0] inc_limit;

	// ==========================================================
	// Limits: 8 << code for decrease, twice that for increase
	assign dec_limit = `DEC_BASE_CYCLES << code;
	assign inc_limit = dec_limit << `INC_SHIFT_EXTRA;

	// Counter restarts at each adjustment; saturates so it never wraps
	always @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= {CNT_W{1'b0}};
		end else if (adjusted) begin
			count_reg <= {CNT_W{1'b0}};
		end else if (mon_tick && count_reg != {CNT_W{1'b1}}) begin
			count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Code is read live, so a new code applies at the next compare
	always @(posedge aclk) begin
		if (!aresetn) begin
			dec_ready <= 1'b0;
			inc_ready <= 1'b0;
		end else begin
			dec_ready <= !adjusted && (count_reg >= dec_limit);
			inc_ready <= !adjusted && (count_reg >= inc_limit);
		end
	end

endmodule // interval_timer

// >>> src/fan_start_temperature_interval_and_duty_ceiling.v
// Fan-start interval codes and fan duty ceilings, AXI4-Lite register bank.
// Assumes monitoring tick, alarm and adjustment-done inputs synchronous to aclk.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "fan_start_temperature_ceiling_consts.vh"

module fan_start_temperature_interval_and_duty_ceiling (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [9:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [9:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        mon_tick,
	input  wire        thermal_alarm_pin,
	input  wire [2:0]  adjust_done,
	output wire [2:0]  dec_allowed,
	output wire [2:0]  inc_allowed,
	output reg  [7:0]  fan_drive_1,
	output reg  [7:0]  fan_drive_2,
	output reg  [7:0]  fan_drive_3
);

	// ==========================================================
	// Register state
	reg  [7:0]  fan_start_temperature_adjust_interval_codes_reg;
	reg  [7:0]  fan1_duty_ceiling_reg;
	reg  [7:0]  fan2_duty_ceiling_reg;
	reg  [7:0]  fan3_duty_ceiling_reg;
	reg         remote2_msb_reg;
	reg         limit_lock_reg;
	reg         force_full_speed_reg;
	reg         ceiling_on_alarm_reg;
	reg  [7:0]  demand1_reg;
	reg  [7:0]  demand2_reg;
	reg  [7:0]  demand3_reg;

	// Write channel holding
	reg  [9:0]  aw_addr_reg;
	reg         aw_held_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg         w_held_reg;

	wire        wr_go;
	wire [7:0]  wr_idx;
	wire [7:0]  wr_byte;
	wire        wr_en;
	wire        wr_unmapped;
	wire        wr_locked;
	wire [7:0]  rd_idx;
	reg  [7:0]  rd_byte;
	reg         rd_hit;

	wire [2:0]  remote1_interval_code;
	wire [2:0]  local_interval_code;
	wire [2:0]  remote2_interval_code;

	// ==========================================================
	// AXI write: address and data taken independently, one at a time
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign wr_go         = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_idx        = aw_addr_reg[9:2];                        // Full 8-bit index reach
	assign wr_byte       = w_data_reg[7:0];
	assign wr_en         = wr_go && w_strb_reg[0];

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 10'h000;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Unmapped addresses answer SLVERR; locked writes complete OKAY but change nothing
	assign wr_unmapped = !(wr_idx == `IDX_INTERVAL  || wr_idx == `IDX_FAN1_CEIL ||
		wr_idx == `IDX_FAN2_CEIL || wr_idx == `IDX_FAN3_CEIL ||
		wr_idx == `IDX_DYN_CTRL1 || wr_idx == `IDX_CONFIG1 ||
		wr_idx == `IDX_CONFIG4   || wr_idx == `IDX_FAN_DEMAND ||
		wr_idx == (`IDX_FAN_DEMAND + 8'h01) || wr_idx == (`IDX_FAN_DEMAND + 8'h02) ||
		wr_idx == `IDX_ADJ_STATUS);
	assign wr_locked = limit_lock_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_unmapped ? `RESP_SLVERR : `RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Lockable registers: interval codes, ceilings, remote 2 upper bit
	always @(posedge aclk) begin
		if (!aresetn) begin
			fan_start_temperature_adjust_interval_codes_reg <= `RST_INTERVAL;
			fan1_duty_ceiling_reg <= `RST_CEILING;
			fan2_duty_ceiling_reg <= `RST_CEILING;
			fan3_duty_ceiling_reg <= `RST_CEILING;
			remote2_msb_reg <= 1'b0;
		end else if (wr_en && !wr_locked) begin
			case (wr_idx)
				`IDX_INTERVAL:  fan_start_temperature_adjust_interval_codes_reg <= wr_byte;
				`IDX_FAN1_CEIL: fan1_duty_ceiling_reg <= wr_byte;
				`IDX_FAN2_CEIL: fan2_duty_ceiling_reg <= wr_byte;
				`IDX_FAN3_CEIL: fan3_duty_ceiling_reg <= wr_byte;
				`IDX_DYN_CTRL1: remote2_msb_reg <= wr_byte[`FLD_DYN1_R2_MSB];
				default: begin
				end
			endcase
		end
	end

	// Lock is write-once: only reset clears it, software never can
	always @(posedge aclk) begin
		if (!aresetn) begin
			limit_lock_reg <= 1'b0;
		end else if (wr_en && wr_idx == `IDX_CONFIG1 && wr_byte[`FLD_CFG1_LOCK]) begin
			limit_lock_reg <= 1'b1;
		end
	end

	// Force-full-speed and alarm mode bits stay writable under lock
	always @(posedge aclk) begin
		if (!aresetn) begin
			force_full_speed_reg <= 1'b0;
			ceiling_on_alarm_reg <= 1'b0;
			demand1_reg <= `RST_DEMAND;
			demand2_reg <= `RST_DEMAND;
			demand3_reg <= `RST_DEMAND;
		end else if (wr_en) begin
			if (wr_idx == `IDX_CONFIG1)
				force_full_speed_reg <= wr_byte[`FLD_CFG1_FORCE];
			if (wr_idx == `IDX_CONFIG4)
				ceiling_on_alarm_reg <= wr_byte[`FLD_CFG4_CEIL_ALM];
			if (wr_idx == `IDX_FAN_DEMAND)
				demand1_reg <= wr_byte;
			if (wr_idx == `IDX_FAN_DEMAND + 8'h01)
				demand2_reg <= wr_byte;
			if (wr_idx == `IDX_FAN_DEMAND + 8'h02)
				demand3_reg <= wr_byte;
		end
	end

	// ==========================================================
	// Interval codes and per-channel timers
	assign remote1_interval_code = fan_start_temperature_adjust_interval_codes_reg[`FLD_REMOTE1_LO +: 3];
	assign local_interval_code   = fan_start_temperature_adjust_interval_codes_reg[`FLD_LOCAL_LO +: 3];
	assign remote2_interval_code = {remote2_msb_reg,
		fan_start_temperature_adjust_interval_codes_reg[`FLD_REMOTE2_LO +: 2]};

	interval_timer #(.CNT_W(12)) u_timer_remote1 (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.mon_tick  (mon_tick),
		.code      (remote1_interval_code),
		.adjusted  (adjust_done[0]),
		.dec_ready (dec_allowed[0]),
		.inc_ready (inc_allowed[0])
	);

	interval_timer #(.CNT_W(12)) u_timer_local (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.mon_tick  (mon_tick),
		.code      (local_interval_code),
		.adjusted  (adjust_done[1]),
		.dec_ready (dec_allowed[1]),
		.inc_ready (inc_allowed[1])
	);

	interval_timer #(.CNT_W(12)) u_timer_remote2 (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.mon_tick  (mon_tick),
		.code      (remote2_interval_code),
		.adjusted  (adjust_done[2]),
		.dec_ready (dec_allowed[2]),
		.inc_ready (inc_allowed[2])
	);

	// ==========================================================
	// Fan drive: alarm first, then force, else demand clipped to ceiling
	// Duty byte is linear, so a plain compare clips it
	always @(posedge aclk) begin
		if (!aresetn) begin
			fan_drive_1 <= `RST_DEMAND;
			fan_drive_2 <= `RST_DEMAND;
			fan_drive_3 <= `RST_DEMAND;
		end else if (thermal_alarm_pin && !ceiling_on_alarm_reg) begin
			fan_drive_1 <= `DUTY_FULL;
			fan_drive_2 <= `DUTY_FULL;
			fan_drive_3 <= `DUTY_FULL;
		end else if (thermal_alarm_pin || force_full_speed_reg) begin
			fan_drive_1 <= fan1_duty_ceiling_reg;
			fan_drive_2 <= fan2_duty_ceiling_reg;
			fan_drive_3 <= fan3_duty_ceiling_reg;
		end else begin
			fan_drive_1 <= (demand1_reg > fan1_duty_ceiling_reg) ?
				fan1_duty_ceiling_reg : demand1_reg;
			fan_drive_2 <= (demand2_reg > fan2_duty_ceiling_reg) ?
				fan2_duty_ceiling_reg : demand2_reg;
			fan_drive_3 <= (demand3_reg > fan3_duty_ceiling_reg) ?
				fan3_duty_ceiling_reg : demand3_reg;
		end
	end

	// ==========================================================
	// AXI read: one outstanding read, answered one cycle after address
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_idx        = s_axi_araddr[9:2];

	always @* begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		case (rd_idx)
			`IDX_INTERVAL:  rd_byte = fan_start_temperature_adjust_interval_codes_reg;
			`IDX_FAN1_CEIL: rd_byte = fan1_duty_ceiling_reg;
			`IDX_FAN2_CEIL: rd_byte = fan2_duty_ceiling_reg;
			`IDX_FAN3_CEIL: rd_byte = fan3_duty_ceiling_reg;
			`IDX_DYN_CTRL1: rd_byte = {7'h00, remote2_msb_reg};
			`IDX_CONFIG1:   rd_byte = {4'h0, force_full_speed_reg, 1'b0,
				limit_lock_reg, 1'b1};
			`IDX_CONFIG4:   rd_byte = {4'h0, ceiling_on_alarm_reg, 3'b000};
			`IDX_FAN_DEMAND: rd_byte = fan_drive_1;
			`IDX_FAN_DEMAND + 8'h01: rd_byte = fan_drive_2;
			`IDX_FAN_DEMAND + 8'h02: rd_byte = fan_drive_3;
			`IDX_ADJ_STATUS: rd_byte = {2'b00, inc_allowed, dec_allowed};
			default:        rd_hit = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, rd_byte};
			s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // fan_start_temperature_interval_and_duty_ceiling

// >>> sim/fan_start_temperature_props.sv
// Port checker for the fan-start interval and duty-ceiling bank.
// Assumes the alarm stays high two cycles only while ceiling-on-alarm is clear.
`timescale 1ns/100ps
// ==========================================================
// Checker
module fan_start_temperature_props (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        thermal_alarm_pin,
	input wire logic [2:0]  adjust_done,
	input wire logic [2:0]  dec_allowed,
	input wire logic [2:0]  inc_allowed,
	input wire logic [7:0]  fan_drive_1,
	input wire logic [7:0]  fan_drive_2,
	input wire logic [7:0]  fan_drive_3
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Registers are one byte wide, so the upper read lanes stay quiet
	chk_rdata_narrow: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	chk_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while answer pending");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write response late");
	// Output is registered, so the second alarm sample sees full duty
	chk_alarm_full: assert property (thermal_alarm_pin [*2] |-> {fan_drive_1, fan_drive_2, fan_drive_3} == 24'hFFFFFF)
		else $error("alarm did not force full duty");
	chk_dec_restart: assert property (adjust_done[0] |=> !dec_allowed[0] [*8])
		else $error("decrease allowed too soon after adjustment");
	chk_inc_restart: assert property (adjust_done[2] |=> !inc_allowed[2] [*8])
		else $error("increase allowed too soon after adjustment");
	// Increase interval is twice the decrease one, so it can never lead
	chk_inc_after_dec: assert property ((inc_allowed & ~dec_allowed) == 3'b000)
		else $error("increase allowed before decrease");
endmodule // fan_start_temperature_props

bind fan_start_temperature_interval_and_duty_ceiling fan_start_temperature_props u_props (.*);

// >>> sim/host_axi_model.sv
// Host software model: a register bus master with slow or prompt answers.
// Assumes one shared clock; callers run one write or one read at a time.
`timescale 1ns/100ps
// ==========================================================
// Bus master
module host_axi_model (
	input  wire logic        aclk,
	output var  logic [9:0]  s_axi_awaddr,
	output var  logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output var  logic [31:0] s_axi_wdata,
	output var  logic [3:0]  s_axi_wstrb,
	output var  logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output var  logic        s_axi_bready,
	output var  logic [9:0]  s_axi_araddr,
	output var  logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output var  logic        s_axi_rready
);
	logic   slow;
	integer n_timeout;
	// Idle bus at time zero
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 56'h0;
		slow = 1'b0;
		n_timeout = 0;
	end
	// Write: released payload is inverted so stale values never look valid
	task wr(input [9:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
		integer i;
		begin
			r = 2'b11;
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_wstrb <= s;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= !slow;
			for (i = 0; i < 64 && r === 2'b11; i = i + 1) begin
				@(posedge aclk);
				if (s_axi_awvalid && s_axi_awready) begin
					s_axi_awvalid <= 1'b0;
					s_axi_awaddr <= ~a;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					s_axi_wvalid <= 1'b0;
					s_axi_wdata <= ~d;
				end
				if (s_axi_bvalid && s_axi_bready) begin
					r = s_axi_bresp;
					s_axi_bready <= 1'b0;
				end else if (s_axi_bvalid)
					s_axi_bready <= 1'b1;
			end
			if (r === 2'b11)
				n_timeout = n_timeout + 1;
		end
	endtask
	// Read: a slow host lets the answer wait one edge before taking it
	task rd(input [9:0] a, output [31:0] d, output [1:0] r);
		integer i;
		begin
			r = 2'b11;
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= !slow;
			for (i = 0; i < 64 && r === 2'b11; i = i + 1) begin
				@(posedge aclk);
				if (s_axi_arvalid && s_axi_arready) begin
					s_axi_arvalid <= 1'b0;
					s_axi_araddr <= ~a;
				end
				if (s_axi_rvalid && s_axi_rready) begin
					r = s_axi_rresp;
					d = s_axi_rdata;
					s_axi_rready <= 1'b0;
				end else if (s_axi_rvalid)
					s_axi_rready <= 1'b1;
			end
			if (r === 2'b11)
				n_timeout = n_timeout + 1;
		end
	endtask
endmodule // host_axi_model

// >>> sim/test_fan_start_temperature_interval_and_duty_ceiling.sv
// Self-checking bench for the fan-start interval and duty-ceiling bank.
// Assumes host_axi_model as bus master and fan_start_temperature_props bound to the bank.
`timescale 1ns/100ps
// ==========================================================
// Bench top
module test_fan_start_temperature_interval_and_duty_ceiling;
	logic        aclk, aresetn, mon_tick, thermal_alarm_pin;
	logic [2:0]  adjust_done;
	wire  [9:0]  s_axi_awaddr, s_axi_araddr;
	wire  [7:0]  fan_drive_1, fan_drive_2, fan_drive_3;
	wire  [31:0] s_axi_wdata, s_axi_rdata;
	wire  [3:0]  s_axi_wstrb;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	wire         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	wire  [2:0]  dec_allowed, inc_allowed;
	wire  [7:0]  fd [0:2];
	integer      n_mismatch, n_tests, i, c, dm, cl;
	integer      mreg [0:255];
	logic [1:0]  r;
	logic [31:0] rv;
	assign fd[0] = fan_drive_1;
	assign fd[1] = fan_drive_2;
	assign fd[2] = fan_drive_3;
	fan_start_temperature_interval_and_duty_ceiling DUT (.*);
	host_axi_model u_host (.*);
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// Value and window compares
	task chk(input string nm, input [31:0] e, input [31:0] g);
		n_tests = n_tests + 1;
		if (g !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chkw(input string nm, input integer e, input integer g);
		n_tests = n_tests + 1;
		if (g < e - 2 || g > e + 2) begin
			n_mismatch = n_mismatch + 1;
			$display("Error %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	// Register access with model upkeep; 0xFC is an unmapped place
	task wreg(input [9:0] a, input [31:0] d);
		u_host.wr(a, d, 4'hF, r);
		chk("write response", (a == 8'hFC) ? 2 : 0, r);
		mreg[a[9:2]] = d & 8'hFF;
	endtask
	task rreg(input [9:0] a);
		logic [31:0] d;
		u_host.rd(a, d, r);
		chk("read response", (a == 8'hFC) ? 2 : 0, r);
		if (a != 8'hFC)
			chk("read data", mreg[a[9:2]], d);
	endtask
	// Model values after reset: interval and remote 2 upper bit clear, ceilings full
	task mrst;
		mreg[54] = 0;
		mreg[55] = 0;
		for (i = 56; i < 59; i = i + 1)
			mreg[i] = 255;
	endtask
	// Time one channel's decrease and increase intervals with a tick every cycle
	task tmr(input integer ch, input integer cd);
		integer n, nd, ni;
		wreg(8'hDC, (ch == 0) ? cd : (ch == 1) ? cd << 3 : (cd & 3) << 6);
		if (ch == 2)
			wreg(8'hD8, cd >> 2);
		@(posedge aclk);
		adjust_done <= 3'b001 << ch;
		mon_tick <= 1'b1;
		@(posedge aclk);
		adjust_done <= 3'b000;
		nd = -1;
		ni = -1;
		for (n = 0; n < 4200 && ni < 0; n = n + 1) begin
			@(negedge aclk);
			if (nd < 0 && dec_allowed[ch])
				nd = n;
			if (inc_allowed[ch])
				ni = n;
		end
		@(posedge aclk);
		mon_tick <= 1'b0;
		chkw("decrease interval", 8 << cd, nd);
		chkw("increase interval", 16 << cd, ni);
	endtask
	task end_sim;
		n_mismatch = n_mismatch + u_host.n_timeout;
		$display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (100000) @(posedge aclk);
		n_mismatch = n_mismatch + 1;
		end_sim;
	end
	// Main sequence
	initial begin
		{aresetn, mon_tick, thermal_alarm_pin, adjust_done} = 6'h00;
		{n_mismatch, n_tests} = 0;
		mrst;
		i = $urandom(65);
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 5; i = i + 1)
			rreg(8'hD8 + 4 * i);
		rreg(8'hDC);
		for (i = 0; i < 4; i = i + 1) begin
			wreg(8'hDC + 4 * i, $urandom);
			rreg(8'hDC + 4 * i);
		end
		wreg(8'hFC, 32'h0000_00A5);
		rreg(8'hFC);
		u_host.slow = 1'b1;
		for (i = 0; i < 3; i = i + 1) begin
			dm = $urandom % 256;
			cl = $urandom % 256;
			wreg(8'hE0 + 4 * i, cl);
			wreg(8'hC0 + 4 * i, dm);
			rreg(8'hE0 + 4 * i);
			repeat (3) @(negedge aclk);
			chk("fan drive", (dm < cl) ? dm : cl, fd[i]);
		end
		@(posedge aclk);
		thermal_alarm_pin <= 1'b1;
		repeat (3) @(negedge aclk);
		for (i = 0; i < 3; i = i + 1)
			chk("alarm drive", 8'hFF, fd[i]);
		@(posedge aclk);
		thermal_alarm_pin <= 1'b0;
		u_host.slow = 1'b0;
		for (i = 0; i < 3; i = i + 1)
			for (c = 0; c < 8; c = c + 1)
				tmr(i, c);
		rreg(8'hDC);
		rreg(8'hD8);
		// Force-full-speed drives every fan at its ceiling
		wreg(10'h100, 32'h08);
		repeat (2) @(negedge aclk);
		for (i = 0; i < 3; i = i + 1)
			chk("force drive", mreg[56 + i], fd[i]);
		wreg(10'h100, 32'h00);
		// Ceiling-on-alarm: a one-cycle alarm keeps the two-cycle full-duty check quiet
		wreg(10'h1F4, 32'h08);
		@(posedge aclk);
		thermal_alarm_pin <= 1'b1;
		@(posedge aclk);
		thermal_alarm_pin <= 1'b0;
		@(negedge aclk);
		for (i = 0; i < 3; i = i + 1)
			chk("alarm ceiling", mreg[56 + i], fd[i]);
		// Lock: later writes complete but change nothing, and software cannot unlock
		wreg(10'h100, 32'h02);
		u_host.wr(10'h0E0, ~mreg[56], 4'hF, r);
		chk("locked ceiling response", 0, r);
		u_host.wr(10'h0DC, ~mreg[55], 4'hF, r);
		chk("locked interval response", 0, r);
		u_host.wr(10'h0D8, ~mreg[54], 4'hF, r);
		chk("locked upper bit response", 0, r);
		wreg(10'h100, 32'h00);
		rreg(8'hE0);
		rreg(8'hDC);
		rreg(8'hD8);
		u_host.rd(10'h100, rv, r);
		chk("lock read response", 0, r);
		chk("lock held", 32'h03, rv);
		// Only a reset clears the lock and restores the power-on values
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		mrst;
		for (i = 0; i < 5; i = i + 1)
			rreg(8'hD8 + 4 * i);
		u_host.rd(10'h100, rv, r);
		chk("lock after reset", 32'h01, rv);
		end_sim;
	end
endmodule // test_fan_start_temperature_interval_and_duty_ceiling
